// ### verilog/cor_pkg.sv
// constants and types shared by the charger option register block
package cor_pkg;

  // byte sub-addresses of the 16-bit option register
  localparam logic [7:0] COR_ADDR_LOW = 8'h34;
  localparam logic [7:0] COR_ADDR_HIGH = 8'h35;

  // whole-register value after power-on reset; soft reset loads it but keeps the re-measure bit
  localparam logic [15:0] COR_RESET_VALUE = 16'h0030;

  // field positions within the 16-bit register
  localparam int COR_HIGH_IMPEDANCE_ENABLE_BIT = 15;
  localparam int COR_REGISTER_RESET_BIT = 14;
  localparam int COR_INPUT_THRESHOLD_REMEASURE_BIT = 13;
  localparam int COR_OUTPUT_MODE_ENABLE_BIT = 12;
  localparam int COR_INPUT_OPTIMISATION_ENABLE_BIT = 11;
  localparam int COR_CONSERVATIVE_SUPPLEMENT_ENABLE_BIT = 6;
  localparam int COR_SHARED_PIN_ROLE_SELECT_BIT = 5;
  localparam int COR_INDUCTOR_AVERAGE_CLAMP_MSB = 4;
  localparam int COR_INDUCTOR_AVERAGE_CLAMP_LSB = 3;
  localparam int COR_OUTPUT_LOW_RANGE_SELECT_BIT = 2;
  localparam int COR_BATTERY_SWITCH_OFF_IN_HIGHZ_BIT = 1;
  localparam int COR_POWER_MONITOR_OUTPUT_SELECT_BIT = 0;

  // inductor average clamp codes and limits in milliamps
  localparam logic [1:0] COR_CLAMP_CODE_6A = 2'h0;
  localparam logic [1:0] COR_CLAMP_CODE_10A = 2'h1;
  localparam logic [1:0] COR_CLAMP_CODE_15A = 2'h2;
  localparam logic [1:0] COR_CLAMP_CODE_OFF = 2'h3;
  localparam logic [15:0] COR_CLAMP_6A_MA = 16'h1770;
  localparam logic [15:0] COR_CLAMP_10A_MA = 16'h2710;
  localparam logic [15:0] COR_CLAMP_15A_MA = 16'h3a98;

  // minimum system voltage single-cell default, 3.584 V in millivolts
  localparam logic [15:0] COR_MIN_SYS_DEFAULT_MV = 16'h0e00;

  // converter stop settle time before the threshold is measured
  localparam int COR_CLK_PERIOD_PS = 10000;
  localparam int COR_SETTLE_NS = 1000;
  localparam int COR_SETTLE_CYCLES = (COR_SETTLE_NS * 1000 + COR_CLK_PERIOD_PS - 1) / COR_CLK_PERIOD_PS;
  localparam int COR_SETTLE_W = 8;

  typedef enum logic [1:0] {
    COR_SEQ_IDLE,
    COR_SEQ_STOP,
    COR_SEQ_MEASURE,
    COR_SEQ_RESTART
  } cor_seq_state_t;

endpackage : cor_pkg

// ### verilog/cor_meas_if.sv
// handshake between option register and threshold re-measure sequencer
`timescale 1ns/1ps
`default_nettype none
interface cor_meas_if;
  logic start;
  logic done;
  logic converter_off;
  logic meas_req;
  logic meas_done;

  modport ctrl (output start, output meas_done, input done, input converter_off, input meas_req);
  modport seq (input start, input meas_done, output done, output converter_off, output meas_req);
endinterface : cor_meas_if
`default_nettype wire

// ### verilog/cor_remeasure_seq.sv
// sequencer that stops the converter, measures the input threshold, restarts
`timescale 1ns/1ps
`default_nettype none
module cor_remeasure_seq #(
  parameter int SETTLE_CYCLES = cor_pkg::COR_SETTLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  cor_meas_if.seq mif
);
  import cor_pkg::*;

  typedef struct packed {
    cor_seq_state_t state;
    logic [COR_SETTLE_W-1:0] settle;
    logic converter_off;
    logic meas_req;
    logic done;
  } cor_seq_regs_t;

  cor_seq_regs_t r_q;
  cor_seq_regs_t r_d;

  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    case (r_q.state)
      COR_SEQ_IDLE: begin
        if (mif.start) begin
          r_d.state = COR_SEQ_STOP;
          r_d.converter_off = 1'b1; // RL7
          r_d.settle = COR_SETTLE_W'(SETTLE_CYCLES - 1);
        end
      end
      COR_SEQ_STOP: begin
        // let the converter wind down before sampling the input
        if (r_q.settle == '0) begin
          r_d.state = COR_SEQ_MEASURE;
          r_d.meas_req = 1'b1;
        end else begin
          r_d.settle = r_q.settle - 1'b1;
        end
      end
      COR_SEQ_MEASURE: begin
        if (mif.meas_done) begin
          r_d.meas_req = 1'b0;
          r_d.done = 1'b1;
          r_d.state = COR_SEQ_RESTART;
        end
      end
      COR_SEQ_RESTART: begin
        r_d.converter_off = 1'b0; // RL7
        r_d.state = COR_SEQ_IDLE;
      end
      default: begin
        r_d.state = COR_SEQ_IDLE;
        r_d.converter_off = 1'b0;
        r_d.meas_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      r_q <= '{state: COR_SEQ_IDLE, settle: '0, converter_off: 1'b0, meas_req: 1'b0, done: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  assign mif.converter_off = r_q.converter_off;
  assign mif.meas_req = r_q.meas_req;
  assign mif.done = r_q.done;

endmodule : cor_remeasure_seq
`default_nettype wire

// ### verilog/cor_option_reg.sv
// charger option control register with its mode and sequencing outputs
//
// Contract
// RL1: high impedance enable bit set puts device in high impedance input mode.
// RL2: in high impedance with input above lockout, regulator on, system on battery.
// RL3: register reset bit restores all registers except the input threshold register.
// RL4: register reset reverts minimum system voltage to 3.584V, charge voltage per cell pin.
// RL5: register reset bit clears itself after the reset is done.
// RL6: host should avoid register reset with low or absent battery.
// RL7: re-measure bit stops converter, measures threshold, clears bit, restarts converter.
// RL8: output mode only when enable bit and output-enable pin are both high.
// RL9: input optimisation runs only while its enable bit is one.
// RL10: lower bit 6 enables conservative supplement mode.
// RL11: lower bit 5 picks shared pin role: supplement mode or output mode.
// RL12: clamp field selects 6A, 10A, 15A or no clamp.
// RL13: lower bit 2 selects low or high output voltage range.
// RL14: lower bit 1 turns battery switch off during high impedance mode.
// RL15: lower bit 0 picks power monitor definition in output mode.
// RL16: reserved bits are plain storage resetting to zero.
// RL17: power-on reset loads 0x0030 into the whole register.
`timescale 1ns/1ps
`default_nettype none
module cor_option_reg #(
  parameter int SETTLE_CYCLES = cor_pkg::COR_SETTLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic input_above_uvlo,
  input wire logic output_enable_pin,
  input wire logic threshold_meas_done,
  output logic threshold_meas_req,
  output logic converter_enable,
  output logic high_impedance_mode,
  output logic internal_regulator_on,
  output logic system_from_battery,
  output logic battery_switch_on,
  output logic output_mode_active,
  output logic supplement_pin_enable,
  output logic input_optimisation_run,
  output logic conservative_supplement_enable,
  output logic inductor_clamp_enable,
  output logic [15:0] inductor_clamp_ma,
  output logic output_low_range_select,
  output logic power_monitor_output_select,
  output logic other_regs_reset,
  output logic [15:0] minimum_system_voltage_mv,
  output logic charge_voltage_from_cell_pin
);
  import cor_pkg::*;

  function automatic logic [15:0] cor_clamp_ma(input logic [1:0] code);
    case (code)
      COR_CLAMP_CODE_6A: cor_clamp_ma = COR_CLAMP_6A_MA;
      COR_CLAMP_CODE_10A: cor_clamp_ma = COR_CLAMP_10A_MA;
      COR_CLAMP_CODE_15A: cor_clamp_ma = COR_CLAMP_15A_MA;
      default: cor_clamp_ma = 16'h0000;
    endcase
  endfunction : cor_clamp_ma

  typedef struct packed {
    logic [15:0] opt;
    logic [7:0] rdata;
    logic rd_valid;
    logic hiz;
    logic regulator_on;
    logic sys_from_batt;
    logic batt_switch_on;
    logic otg_active;
    logic supp_pin_en;
    logic ico_run;
    logic cons_supp;
    logic clamp_en;
    logic [15:0] clamp_ma;
    logic low_range;
    logic system_power_monitor_sel;
    logic others_reset;
    logic [15:0] sysmin_mv;
    logic chg_v_cell_pin;
  } cor_regs_t;

  cor_regs_t r_q;
  cor_regs_t r_d;

  cor_meas_if mif ();

  cor_remeasure_seq #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_remeasure (
    .core_clk(core_clk),
    .rstn(rstn),
    .mif(mif)
  );

  logic [15:0] opt_wr;
  logic remeas_write_one;

  always_comb begin
    r_d = r_q;
    r_d.rd_valid = 1'b0;
    r_d.others_reset = 1'b0;
    r_d.chg_v_cell_pin = 1'b0;
    remeas_write_one = 1'b0;

    // byte writes merge into the 16-bit word
    opt_wr = r_q.opt;
    if (reg_wr_en && reg_addr == COR_ADDR_LOW) begin
      opt_wr[7:0] = reg_wdata; // RL16
    end
    if (reg_wr_en && reg_addr == COR_ADDR_HIGH) begin
      opt_wr[15:8] = reg_wdata; // RL16
      remeas_write_one = reg_wdata[COR_INPUT_THRESHOLD_REMEASURE_BIT - 8];
    end

    // the re-measure bit is owned by hardware while a measurement runs;
    // a host write of one wins over the completion clear
    if (remeas_write_one) begin
      opt_wr[COR_INPUT_THRESHOLD_REMEASURE_BIT] = 1'b1;
    end else if (r_q.opt[COR_INPUT_THRESHOLD_REMEASURE_BIT] && !mif.done) begin
      opt_wr[COR_INPUT_THRESHOLD_REMEASURE_BIT] = 1'b1;
    end else begin
      opt_wr[COR_INPUT_THRESHOLD_REMEASURE_BIT] = 1'b0; // RL7
    end

    if (r_q.opt[COR_REGISTER_RESET_BIT]) begin
      // soft reset: defaults everywhere, threshold measurement left alone
      r_d.opt = COR_RESET_VALUE; // RL3
      r_d.opt[COR_INPUT_THRESHOLD_REMEASURE_BIT] = opt_wr[COR_INPUT_THRESHOLD_REMEASURE_BIT]; // RL3
      r_d.opt[COR_REGISTER_RESET_BIT] = 1'b0; // RL5
      r_d.others_reset = 1'b1; // RL3
      r_d.sysmin_mv = COR_MIN_SYS_DEFAULT_MV; // RL4
      r_d.chg_v_cell_pin = 1'b1; // RL4
    end else begin
      r_d.opt = opt_wr;
    end

    if (reg_rd_en) begin
      r_d.rd_valid = 1'b1;
      case (reg_addr)
        COR_ADDR_LOW: r_d.rdata = r_q.opt[7:0];
        COR_ADDR_HIGH: r_d.rdata = r_q.opt[15:8];
        default: r_d.rdata = 8'h00;
      endcase
    end

    // mode outputs follow the stored fields
    r_d.hiz = r_q.opt[COR_HIGH_IMPEDANCE_ENABLE_BIT]; // RL1
    r_d.regulator_on = !r_q.opt[COR_HIGH_IMPEDANCE_ENABLE_BIT] || input_above_uvlo; // RL2
    r_d.sys_from_batt = r_q.opt[COR_HIGH_IMPEDANCE_ENABLE_BIT] && input_above_uvlo; // RL2
    r_d.batt_switch_on = !(r_q.opt[COR_HIGH_IMPEDANCE_ENABLE_BIT]
                           && r_q.opt[COR_BATTERY_SWITCH_OFF_IN_HIGHZ_BIT]); // RL14
    r_d.otg_active = r_q.opt[COR_OUTPUT_MODE_ENABLE_BIT] && output_enable_pin
                     && r_q.opt[COR_SHARED_PIN_ROLE_SELECT_BIT]; // RL8 RL11
    r_d.supp_pin_en = !r_q.opt[COR_SHARED_PIN_ROLE_SELECT_BIT] && output_enable_pin; // RL11
    r_d.ico_run = r_q.opt[COR_INPUT_OPTIMISATION_ENABLE_BIT]; // RL9
    r_d.cons_supp = r_q.opt[COR_CONSERVATIVE_SUPPLEMENT_ENABLE_BIT]; // RL10
    r_d.clamp_en = r_q.opt[COR_INDUCTOR_AVERAGE_CLAMP_MSB:COR_INDUCTOR_AVERAGE_CLAMP_LSB]
                   != COR_CLAMP_CODE_OFF; // RL12
    r_d.clamp_ma = cor_clamp_ma(r_q.opt[COR_INDUCTOR_AVERAGE_CLAMP_MSB:COR_INDUCTOR_AVERAGE_CLAMP_LSB]); // RL12
    r_d.low_range = r_q.opt[COR_OUTPUT_LOW_RANGE_SELECT_BIT]; // RL13
    r_d.system_power_monitor_sel = r_q.opt[COR_POWER_MONITOR_OUTPUT_SELECT_BIT]; // RL15
  end

  // start only from idle; the bit stays set until the sequencer reports done
  assign mif.start = r_q.opt[COR_INPUT_THRESHOLD_REMEASURE_BIT]; // RL7
  assign mif.meas_done = threshold_meas_done;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      r_q <= '0;
      r_q.opt <= COR_RESET_VALUE; // RL17
      r_q.regulator_on <= 1'b1;
      r_q.batt_switch_on <= 1'b1;
      r_q.clamp_en <= 1'b1;
      r_q.clamp_ma <= COR_CLAMP_15A_MA;
      r_q.sysmin_mv <= COR_MIN_SYS_DEFAULT_MV;
    end else begin
      r_q <= r_d;
    end
  end

  assign reg_rdata = r_q.rdata;
  assign reg_rd_valid = r_q.rd_valid;
  assign threshold_meas_req = mif.meas_req;
  assign converter_enable = !mif.converter_off; // RL7
  assign high_impedance_mode = r_q.hiz;
  assign internal_regulator_on = r_q.regulator_on;
  assign system_from_battery = r_q.sys_from_batt;
  assign battery_switch_on = r_q.batt_switch_on;
  assign output_mode_active = r_q.otg_active;
  assign supplement_pin_enable = r_q.supp_pin_en;
  assign input_optimisation_run = r_q.ico_run;
  assign conservative_supplement_enable = r_q.cons_supp;
  assign inductor_clamp_enable = r_q.clamp_en;
  assign inductor_clamp_ma = r_q.clamp_ma;
  assign output_low_range_select = r_q.low_range;
  assign power_monitor_output_select = r_q.system_power_monitor_sel;
  assign other_regs_reset = r_q.others_reset;
  assign minimum_system_voltage_mv = r_q.sysmin_mv;
  assign charge_voltage_from_cell_pin = r_q.chg_v_cell_pin;

endmodule : cor_option_reg
`default_nettype wire

// ### verif/cor_option_reg_assertions.sv
// port assertions for the charger option register
`timescale 1ns/1ps
`default_nettype none
module cor_option_reg_assertions #(
  parameter int SETTLE_CYCLES = 2
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic output_enable_pin,
  input wire logic threshold_meas_done,
  input wire logic threshold_meas_req,
  input wire logic converter_enable,
  input wire logic high_impedance_mode,
  input wire logic internal_regulator_on,
  input wire logic system_from_battery,
  input wire logic output_mode_active,
  input wire logic inductor_clamp_enable,
  input wire logic [15:0] inductor_clamp_ma,
  input wire logic other_regs_reset,
  input wire logic charge_voltage_from_cell_pin
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  chk_hiz_write_follows: assert property (reg_wr_en && reg_addr == 8'h35
    |-> ##2 high_impedance_mode == $past(reg_wdata[7], 2)) else $error("hiz mode not from write");
  chk_hiz_battery_power: assert property (system_from_battery
    |-> high_impedance_mode && internal_regulator_on) else $error("battery power outside hiz");
  chk_soft_reset_pulse: assert property (reg_wr_en && reg_addr == 8'h35 && reg_wdata[6]
    |-> ##2 other_regs_reset && charge_voltage_from_cell_pin ##1 !other_regs_reset) else $error("reset pulse");
  chk_remeasure_stops: assert property (reg_wr_en && reg_addr == 8'h35 && reg_wdata[5]
    && converter_enable && !threshold_meas_req |-> ##2 !converter_enable) else $error("converter kept on");
  chk_meas_req_holds: assert property (threshold_meas_req && !threshold_meas_done
    |=> threshold_meas_req) else $error("request dropped early");
  chk_conv_off_measuring: assert property (threshold_meas_req |-> !converter_enable)
    else $error("converter on while measuring");
  chk_output_needs_pin: assert property (output_mode_active |-> $past(output_enable_pin))
    else $error("output mode without pin");
  chk_clamp_code_map: assert property (inductor_clamp_ma inside {16'h1770, 16'h2710, 16'h3a98}
    || (!inductor_clamp_enable && inductor_clamp_ma == 16'h0000)) else $error("bad clamp value");
  chk_unmapped_read_zero: assert property (reg_rd_en && reg_addr != 8'h34 && reg_addr != 8'h35
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_read_valid_cause: assert property (reg_rd_valid |-> $past(reg_rd_en))
    else $error("stray read valid");
  cover property (other_regs_reset);
  cover property (threshold_meas_done);
  cover property (output_mode_active);
endmodule : cor_option_reg_assertions
bind cor_option_reg cor_option_reg_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (.core_clk, .rstn,
  .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid, .output_enable_pin,
  .threshold_meas_done, .threshold_meas_req, .converter_enable, .high_impedance_mode, .internal_regulator_on,
  .system_from_battery, .output_mode_active, .inductor_clamp_enable, .inductor_clamp_ma, .other_regs_reset,
  .charge_voltage_from_cell_pin);
`default_nettype wire

// ### verif/cor_meas_responder.sv
// analog threshold measurement model answering after a set delay
`timescale 1ns/1ps
`default_nettype none
module cor_meas_responder (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] delay,
  input wire logic threshold_meas_req,
  output logic threshold_meas_done
);
  logic [7:0] cnt_q;
  // one-cycle done pulse; a level would restart the next request at once
  always_ff @(posedge core_clk) begin
    if (!rstn || !threshold_meas_req || threshold_meas_done) begin
      cnt_q <= 8'h00;
      threshold_meas_done <= 1'b0;
    end else if (cnt_q == delay) begin
      threshold_meas_done <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : cor_meas_responder
`default_nettype wire

// ### verif/charger_option_control_reg_bench.sv
// register tests for the charger option register
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module charger_option_control_reg_bench;
  import cor_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic input_above_uvlo = 1'b1;
  logic output_enable_pin = 1'b1;
  logic [7:0] resp_delay = 8'h01;
  logic [7:0] reg_rdata;
  logic [15:0] inductor_clamp_ma, minimum_system_voltage_mv;
  logic reg_rd_valid, threshold_meas_done, threshold_meas_req, converter_enable, high_impedance_mode;
  logic internal_regulator_on, system_from_battery, battery_switch_on, output_mode_active;
  logic supplement_pin_enable, input_optimisation_run, conservative_supplement_enable, inductor_clamp_enable;
  logic output_low_range_select, power_monitor_output_select, other_regs_reset, charge_voltage_from_cell_pin;
  logic [15:0] clamp_ma [4] = '{COR_CLAMP_6A_MA, COR_CLAMP_10A_MA, COR_CLAMP_15A_MA, 16'h0000};
  int fails = 0;
  int comparisons = 0;
  bit pulse_seen;
  // cycles with a measurement request seen high at the rising edge
  int meas_cycles = 0;
  int meas_start;
  cor_option_reg #(.SETTLE_CYCLES(2)) i_dut (.core_clk, .rstn, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rd_valid, .input_above_uvlo, .output_enable_pin, .threshold_meas_done, .threshold_meas_req,
    .converter_enable, .high_impedance_mode, .internal_regulator_on, .system_from_battery, .battery_switch_on,
    .output_mode_active, .supplement_pin_enable, .input_optimisation_run, .conservative_supplement_enable,
    .inductor_clamp_enable, .inductor_clamp_ma, .output_low_range_select, .power_monitor_output_select,
    .other_regs_reset, .minimum_system_voltage_mv, .charge_voltage_from_cell_pin);
  cor_meas_responder i_resp (.core_clk, .rstn, .delay(resp_delay), .threshold_meas_req, .threshold_meas_done);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (other_regs_reset && charge_voltage_from_cell_pin) pulse_seen <= 1'b1;
    if (threshold_meas_req) meas_cycles <= meas_cycles + 1;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  // trailing idle cycle keeps back-to-back calls from re-driving the strobe in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr_en = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd_en = 1'b1;
    reg_addr = a;
    tick(1);
    // valid stands for one cycle only, so look before the strobe drops
    `CHK(reg_rd_valid, 1'b1)
    `CHK(reg_rdata, e)
    reg_rd_en = 1'b0;
    tick(1);
  endtask : rd
  task automatic wait_conv(input logic v);
    for (int i = 0; i < 300 && converter_enable !== v; i++) tick(1);
    if (converter_enable !== v) begin
      fails++;
      $display("unexpected at %0t: converter enable stuck", $time);
      tally_and_finish();
    end
  endtask : wait_conv
  initial begin
    tick(16);
    rstn = 1'b1;
    tick(1);
    `CHK(inductor_clamp_ma, COR_CLAMP_15A_MA)
    `CHK(minimum_system_voltage_mv, COR_MIN_SYS_DEFAULT_MV)
    rd(COR_ADDR_LOW, 8'h30);
    rd(COR_ADDR_HIGH, 8'h00);
    wr(8'h36, 8'hff);
    rd(8'h36, 8'h00);
    rd(COR_ADDR_LOW, 8'h30);
    wr(COR_ADDR_HIGH, 8'h9f);
    rd(COR_ADDR_HIGH, 8'h9f);
    `CHK(high_impedance_mode, 1'b1)
    `CHK(system_from_battery, 1'b1)
    `CHK(internal_regulator_on, 1'b1)
    `CHK(input_optimisation_run, 1'b1)
    `CHK(output_mode_active, 1'b1)
    input_above_uvlo = 1'b0;
    tick(2);
    `CHK(system_from_battery, 1'b0)
    `CHK(internal_regulator_on, 1'b0)
    input_above_uvlo = 1'b1;
    output_enable_pin = 1'b0;
    tick(2);
    `CHK(output_mode_active, 1'b0)
    for (int c = 0; c < 4; c++) begin
      wr(COR_ADDR_LOW, 8'hc7 | 8'(c << 3));
      rd(COR_ADDR_LOW, 8'hc7 | 8'(c << 3));
      `CHK(inductor_clamp_ma, clamp_ma[c])
      `CHK(inductor_clamp_enable, 1'(c != 3))
    end
    `CHK(conservative_supplement_enable, 1'b1)
    `CHK(output_low_range_select, 1'b1)
    `CHK(power_monitor_output_select, 1'b1)
    `CHK(battery_switch_on, 1'b0)
    output_enable_pin = 1'b1;
    tick(2);
    `CHK(supplement_pin_enable, 1'b1)
    `CHK(output_mode_active, 1'b0)
    // battery assumed present, so the soft reset is a permitted use
    wr(COR_ADDR_HIGH, 8'h40);
    rd(COR_ADDR_HIGH, 8'h00);
    rd(COR_ADDR_LOW, 8'h30);
    `CHK(pulse_seen, 1'b1)
    `CHK(minimum_system_voltage_mv, COR_MIN_SYS_DEFAULT_MV)
    `CHK(battery_switch_on, 1'b1)
    for (int d = 1; d < 80; d += 39) begin
      resp_delay = 8'(d);
      meas_start = meas_cycles;
      wr(COR_ADDR_HIGH, 8'h20);
      wait_conv(1'b0);
      wait_conv(1'b1);
      // request stands from its rise until done is taken: responder delay plus two
      `CHK(meas_cycles - meas_start, d + 2)
      rd(COR_ADDR_HIGH, 8'h00);
    end
    tally_and_finish();
  end
endmodule : charger_option_control_reg_bench
`default_nettype wire
